// ---- verification/cis_core_exec_props.sv ----
// Port checks for the instruction executor
`timescale 1ns/1ps
module cis_chk (
	input logic clk, rst, instr_valid, file_we, stack_push, zero_out, zero_we, flush, busy,
	input logic [13:0] instr,
	input logic [12:0] pc, stack_top,
	input logic [7:0] working, file_wdata, file_rdata, pc_latch_high
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Instruction taken at this edge
	wire go = instr_valid && !busy;
	sequence call_s; go && instr[13:11] == 3'h4; endsequence
	chk_call_push: assert property (call_s |=>
		stack_push && stack_top == $past(pc) + 1) else $error("push");
	chk_call_dest: assert property (call_s |=>
		pc[10:0] == $past(instr[10:0])) else $error("dest");
	chk_call_len: assert property (call_s |=>
		busy && flush ##1 !busy) else $error("len");
	chk_call_page: assert property (call_s |=>
		pc[12:11] == $past(pc_latch_high[4:3])) else $error("page");
	chk_skip_flush: assert property (go && instr[13:10] == 4'h7 && file_rdata[instr[9:7]] |=>
		flush && busy) else $error("skip");
	chk_clear_w: assert property (go && instr == 14'h103 |=>
		!working && zero_out) else $error("clear working");
	chk_lit_load: assert property (go && instr[13:10] == 4'hc |=>
		working == $past(instr[7:0]) && !zero_we) else $error("lit");
	chk_move_w: assert property (go && instr[13:7] == 7'h1 |=>
		file_we && file_wdata == $past(working)) else $error("movwf");
	chk_clr_file: assert property (go && instr[13:7] == 7'h3 |=>
		file_we && !file_wdata && zero_out) else $error("clrf");
	chk_move_zero: assert property (go && instr[13:8] == 6'h8 |=>
		zero_out == ($past(file_rdata) == 0)) else $error("move file zero");
endmodule // cis_chk
bind cis_core_exec cis_chk u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid),
	.file_we(file_we), .stack_push(stack_push), .zero_out(zero_out), .zero_we(zero_we),
	.flush(flush), .busy(busy), .instr(instr), .pc(pc), .stack_top(stack_top),
	.working(working), .file_wdata(file_wdata), .file_rdata(file_rdata),
	.pc_latch_high(pc_latch_high));

// ---- verification/cis_core_exec_tb.sv ----
// Bench for the instruction executor
`timescale 1ns/1ps
module cis_core_exec_tb;
	logic clk = 0, rst = 1, instr_valid = 0, file_we, stack_push, zero_out, zero_we, flush;
	logic busy, pc_load;
	logic [13:0] instr = 0;
	logic [12:0] pc, stack_top;
	logic [7:0] file_addr, file_wdata, file_rdata, working;
	int num_errors, cmp_count;
	logic [21:0] rows [8] = '{22'h309191, 22'h335555, 22'h309191, 22'h040593, 22'h008a93,
		22'h010300, 22'h080a93, 22'h048593};
	cis_core_exec DUT (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
		.pc_latch_high(8'h18), .file_select_pointer(8'h0c), .file_rdata(file_rdata),
		.zero_in(zero_out), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
		.stack_push(stack_push), .stack_top(stack_top), .pc(pc), .pc_load(pc_load),
		.working(working), .zero_out(zero_out), .zero_we(zero_we), .flush(flush), .busy(busy));
	cis_file_model m (.clk(clk), .file_we(file_we), .file_addr(file_addr),
		.file_wdata(file_wdata), .file_rdata(file_rdata));
	// Clock
	initial forever #12.5 clk = ~clk;
	task chk(string s, logic [12:0] e, g);
		cmp_count++;
		if (g !== e) num_errors++;
		if (g !== e) $display("MISMATCH %s %h %h", s, e, g);
	endtask
	task go(logic [13:0] x);
		@(posedge clk) instr <= x;
		instr_valid <= 1;
		@(posedge clk) instr_valid <= 0;
		#1;
	endtask
	task finish_test;
		$display("cmp %0d err %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000 num_errors++;
		finish_test;
	end
	// Tests
	initial begin
		m.mem[5] = 8'h13;
		repeat (3) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) begin
			go(rows[i][21:8]);
			chk("w", rows[i][7:0], working);
		end
		$display("table done");
		@(posedge clk) #1 chk("f5", 8'h93, m.mem[5]);
		go(14'h0185);
		go(14'h0080);
		@(posedge clk) #1 chk("f12", 8'h93, m.mem[12]);
		go(14'h27ff);
		chk("pc", 13'h1fff, pc);
		chk("pl", 1, pc_load);
		go(14'h1c0a);
		chk("fl", 1, flush);
		$display("hand done");
		finish_test;
	end
endmodule // cis_core_exec_tb

// ---- verification/cis_file_model.sv ----
// File register array beside the executor
`timescale 1ns/1ps
module cis_file_model (input logic clk, file_we, input logic [7:0] file_addr, file_wdata,
	output logic [7:0] file_rdata);
	logic [7:0] mem [256];
	// Read is combinational, write lands at the edge
	assign file_rdata = mem[file_addr];
	always @(posedge clk) if (file_we) mem[file_addr] <= file_wdata;
endmodule // cis_file_model

// ---- verilog/cis_core_exec.v ----
// Decode and execute of a subset of the 14-bit instruction set
//
// How it works
// - A call pushes the address after the call at the same edge that the counter changes.
// - Call target's 11 low opcode bits load counter bits 10 to 0.
// - Counter bits 12 and 11 come from latch-high bits 4 and 3.
// - A call takes two cycles and leaves the zero flag alone.
// - OR working with file; destination bit picks working or file.
// - Move-file updates the zero flag from the moved value either way.
// - Move-literal loads eight-bit literal into working, flags untouched, one cycle.
// - Move-literal decodes whatever the two don't-care bits hold.
// - Move-working writes working into the addressed file, flags untouched.
// - The indirect location redirects access to the pointer's address.
`timescale 1ns/1ps
`include "cis_map.vh"

// Indirect writes are passed on; the file array decides what they do.
// The zero flag lives outside; zero_out shows the last value written to it.
// The counter steps again in the second cycle of a call or a taken skip.
// Instructions outside the subset run as no-operations.

module cis_core_exec #(
	parameter PC_W   = 13,
	parameter DATA_W = 8
) (
	clk,
	rst,
	instr,
	instr_valid,
	pc_latch_high,
	file_select_pointer,
	file_rdata,
	zero_in,
	file_addr,
	file_wdata,
	file_we,
	stack_push,
	stack_top,
	pc,
	pc_load,
	working,
	zero_out,
	zero_we,
	flush,
	busy
);
	// Port kinds and widths
	input  wire              clk;
	input  wire              rst;
	input  wire [13:0]       instr;
	input  wire              instr_valid;
	input  wire [7:0]        pc_latch_high;
	input  wire [7:0]        file_select_pointer;
	input  wire [DATA_W-1:0] file_rdata;
	input  wire              zero_in;
	output wire [7:0]        file_addr;
	output reg  [DATA_W-1:0] file_wdata;
	output reg               file_we;
	output reg               stack_push;
	output reg  [PC_W-1:0]   stack_top;
	output reg  [PC_W-1:0]   pc;
	output reg               pc_load;
	output reg  [DATA_W-1:0] working;
	output reg               zero_out;
	output reg               zero_we;
	output reg               flush;
	output wire              busy;

	// Second-cycle marker and next values of every register
	reg              stall_reg;
	reg              stall_next;
	reg [PC_W-1:0]   pc_next;
	reg [DATA_W-1:0] w_next;
	reg [DATA_W-1:0] fw_next;
	reg              fwe_next;
	reg              push_next;
	reg              load_next;
	reg              z_next;
	reg              zwe_next;
	reg              flush_next;
	reg [DATA_W-1:0] res;

	// Zero test shared by the OR and move-file instructions
	function is_zero;
		input [DATA_W-1:0] v;
		begin
			is_zero = (v == {DATA_W{1'b0}});
		end
	endfunction

	// Program counter step, wraps at the top of the space
	function [PC_W-1:0] pc_inc;
		input [PC_W-1:0] p;
		begin
			pc_inc = p + {{(PC_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// Operand fields of the current word
	wire [6:0] fsel   = instr[6:0];
	wire       dest   = instr[`CIS_DEST_BIT];
	wire       is_ind = (fsel == `CIS_IND_ADDR);

	// Indirect location routes through the pointer
	assign file_addr = is_ind ? file_select_pointer : {1'b0, fsel};
	assign busy      = stall_reg;

	// Decode and compute the next state of every output
	always @* begin
		stall_next = 1'b0;
		pc_next    = pc_inc(pc);
		w_next     = working;
		fw_next    = file_wdata;
		fwe_next   = 1'b0;
		push_next  = 1'b0;
		load_next  = 1'b0;
		z_next     = zero_in;
		zwe_next   = 1'b0;
		flush_next = 1'b0;
		res        = file_rdata;
		if (stall_reg || !instr_valid) begin
			// Second cycle of a two-cycle instruction runs as a no-op
			pc_next = pc;
			if (stall_reg)
				pc_next = pc_inc(pc);
			if (!instr_valid && !stall_reg)
				pc_next = pc;
		end else if (instr[13:11] == `CIS_OP_CALL_HI) begin
			// Call: save return, jump, drop the prefetched word
			push_next  = 1'b1;
			stall_next = 1'b1;
			load_next  = 1'b1;
			flush_next = 1'b1;
			pc_next    = {pc_latch_high[`CIS_PCL_SEL_HI:`CIS_PCL_SEL_LO],
				instr[10:0]};
		end else if (instr == `CIS_OP_CLEAR_W) begin
			// Clear working register
			w_next   = {DATA_W{1'b0}};
			z_next   = 1'b1;
			zwe_next = 1'b1;
		end else if (instr[13:7] == `CIS_OP_CLRF_HI) begin
			// Clear file register
			fw_next  = {DATA_W{1'b0}};
			fwe_next = 1'b1;
			z_next   = 1'b1;
			zwe_next = 1'b1;
		end else if (instr[13:7] == `CIS_OP_MOVWF_HI) begin
			// Store working register, flags kept
			fw_next  = working;
			fwe_next = 1'b1;
		end else if (instr[13:8] == `CIS_OP_IOR_HI) begin
			// Inclusive OR, result to working or file
			res      = working | file_rdata;
			z_next   = is_zero(res);
			zwe_next = 1'b1;
			if (dest) begin
				fw_next  = res;
				fwe_next = 1'b1;
			end else
				w_next = res;
		end else if (instr[13:8] == `CIS_OP_MOVE_FILE_HI) begin
			// Move file, zero flag always updated
			z_next   = is_zero(file_rdata);
			zwe_next = 1'b1;
			if (dest) begin
				fw_next  = file_rdata;
				fwe_next = 1'b1;
			end else
				w_next = file_rdata;
		end else if (instr[13:10] == `CIS_OP_MOVLW_HI) begin
			// Literal load, don't-care bits ignored
			w_next = instr[7:0];
		end else if (instr[13:10] == `CIS_OP_BTFSS_HI) begin
			// Bit test, skip when the bit is set
			if (file_rdata[instr[9:7]]) begin
				stall_next = 1'b1;
				flush_next = 1'b1;
			end
		end
	end

	// State and registered outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stall_reg  <= 1'b0;
			pc         <= `CIS_PC_RESET;
			working    <= `CIS_W_RESET;
			file_wdata <= {DATA_W{1'b0}};
			file_we    <= 1'b0;
			stack_push <= 1'b0;
			pc_load    <= 1'b0;
			zero_we    <= 1'b0;
			flush      <= 1'b0;
		end else begin
			stall_reg  <= stall_next;
			pc         <= pc_next;
			working    <= w_next;
			file_wdata <= fw_next;
			file_we    <= fwe_next;
			stack_push <= push_next;
			pc_load    <= load_next;
			zero_we    <= zwe_next;
			flush      <= flush_next;
		end
	end

	// Return address captured only on a call
	always @(posedge clk or posedge rst) begin
		if (rst)
			stack_top <= `CIS_PC_RESET;
		else if (push_next)
			stack_top <= pc_inc(pc);
	end

	// Zero flag copy, held between flag writes
	always @(posedge clk or posedge rst) begin
		if (rst)
			zero_out <= 1'b0;
		else if (zwe_next)
			zero_out <= z_next;
	end
endmodule // cis_core_exec

// ---- verilog/cis_map.vh ----
// Opcode patterns, field positions and reset values for the instruction executor
`ifndef CIS_MAP_VH
`define CIS_MAP_VH
`define CIS_OP_CALL_HI     3'b100
`define CIS_OP_CLEAR_W     14'h0103
`define CIS_OP_CLRF_HI     7'b0000011
`define CIS_OP_MOVWF_HI    7'b0000001
`define CIS_OP_IOR_HI      6'b000100
`define CIS_OP_MOVE_FILE_HI 6'b001000
`define CIS_OP_MOVLW_HI    4'b1100
`define CIS_OP_BTFSS_HI    4'b0111
`define CIS_DEST_BIT       7
`define CIS_PCL_SEL_HI     4
`define CIS_PCL_SEL_LO     3
`define CIS_IND_ADDR       7'h00
`define CIS_W_RESET        8'h00
`define CIS_PC_RESET       13'h0000
`define CIS_CALL_CYCLES    2
`endif
